/* csc_pkg.sv */
// Summary of operation
// - medium speed crystal setting covers 100 kHz to 4 MHz crystals and resonators.
// - high speed crystal setting covers 4 MHz to 18 MHz crystals and resonators.
// - clock output only when no clock, rtc or watchdog uses the crystal.
// - clock output drives its pin only while clock_out_pin_enable is set.
// - clock output toggles at half the cpu clock; software may disable it.
// - six-bit rc trim register loads a factory value at reset.
// - software may rewrite the trim at any time; the rc oscillator follows it.
// - doubler bit set makes the rc path deliver twice the base frequency.
// - reset clears the low power access select; software sets it at slow clocks.
// - external clock mode takes the crystal input pin from 0 Hz to 18 MHz.
// - in external clock mode the crystal output pin is port or clock output.
// - watchdog oscillator is a separate 400 kHz source for low power use.
// - source switches between watchdog, rc and external while code runs; here the cpu clock is held until the new source's wake ends.
// - clock_switch_done clears when a switch starts, sets when it completes.
// - crystal sources wait 1024 oscillator cycles plus 60 to 100 us.
// - rc source waits 200 to 300 us before the cpu clock runs.
// - watchdog or external source waits 32 oscillator cycles.
// - programmable divider derives cpu clock with ratios up to 510.
// - divider may change at any time without stopping execution.
// - cpu clock is limited to 18 MHz.
// - low speed crystal setting covers 20 kHz to 100 kHz.
// - at reset source select loads from user config byte1, doubler from byte2.
// - peripheral clock runs at half the cpu clock.
package csc_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CLK_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_TRIM      = 8'h04;
  localparam logic [7:0] ADDR_DIV_RATIO = 8'h08;
  localparam logic [7:0] ADDR_AUX1      = 8'h0C;
  localparam logic [7:0] ADDR_ROUTE     = 8'h10;
  // ==========================================
  // field positions
  localparam int CTRL_DONE_BIT    = 7;
  localparam int CTRL_DBL_BIT     = 3;
  localparam int TRIM_COUT_EN_BIT = 6;
  localparam int AUX1_LP_BIT      = 7;
  localparam int CFG2_DBL_BIT     = 7;
  // ==========================================
  // reset values
  localparam logic [5:0] TRIM_FACTORY_RST = 6'h20;
  localparam logic [7:0] DIV_RATIO_RST    = 8'h00;
  // ==========================================
  // source select encodings
  localparam logic [2:0] SRC_XTAL_HI  = 3'h0;
  localparam logic [2:0] SRC_XTAL_MED = 3'h1;
  localparam logic [2:0] SRC_XTAL_LO  = 3'h2;
  localparam logic [2:0] SRC_RC       = 3'h3;
  localparam logic [2:0] SRC_WDOG     = 3'h4;
  localparam logic [2:0] SRC_EXT      = 3'h7;
  // ==========================================
  // wake-up timing
  localparam int CLK_HZ           = 10_000_000;
  localparam int XTAL_OSC_CYC     = 1024;
  localparam int XTAL_EXTRA_MIN_US = 60;
  localparam int RC_WAKE_MIN_US   = 200;
  localparam int WDEXT_OSC_CYC    = 32;
  localparam int XTAL_EXTRA_CYC   = (XTAL_EXTRA_MIN_US * (CLK_HZ / 1_000_000));
  localparam int RC_WAKE_CYC      = (RC_WAKE_MIN_US * (CLK_HZ / 1_000_000));
  localparam int WAKE_W           = 12;
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OSC  = 3'b010,
    SW_TIME = 3'b100
  } csc_sw_state_t;
endpackage : csc_pkg

/* csc_edge_sync.sv */
`timescale 1ns/1ns
module csc_edge_sync (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [2:0] arm_q;
  // ==========================================
  // two-stage synchroniser, edge seen after stage two
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      arm_q <= 3'h0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end
  // no edge until stage three holds a real sample: a pin high at reset is no tick
  assign rise = s2_q & ~s3_q & arm_q[2];
endmodule : csc_edge_sync

/* csc_divider.sv */
`timescale 1ns/1ns
module csc_divider #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio,
  output logic              tick_out
);
  logic [W-1:0] cnt_q;
  logic         half_q;
  // ==========================================
  // zero passes through, n gives one pulse per 2n input ticks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      half_q <= 1'b0;
    end else if (tick_in && ratio != '0) begin
      // a new ratio only shortens or lengthens the current count
      if (cnt_q >= ratio - W'(1)) begin
        cnt_q  <= '0;
        half_q <= ~half_q;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end
  assign tick_out = tick_in & ((ratio == '0) |
                    (half_q & (cnt_q >= ratio - W'(1))));
endmodule : csc_divider

/* csc_clock_ctrl.sv */
`timescale 1ns/1ns
module csc_clock_ctrl #(
  parameter int DIV_W = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hsel,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  user_config_byte1,
  input  wire logic [7:0]  user_config_byte2,
  input  wire logic        crystal_in_pin,
  input  wire logic        rc_osc_tick,
  input  wire logic        wdog_osc_tick,
  input  wire logic        xtal_osc_tick,
  output logic             cpu_clock_en,
  output logic             periph_clock_en,
  output logic             clock_out_pin,
  output logic             crystal_out_oe,
  output logic [5:0]       rc_trim,
  output logic             rc_doubler_bit,
  output logic             low_power_access_sel,
  output logic [2:0]       osc_source_sel
);
  import csc_pkg::*;

  // ==========================================
  // state
  logic [2:0]       src_q;
  logic [2:0]       src_next_q;
  logic             dbl_q;
  logic             done_q;
  logic [5:0]       trim_q;
  logic             clock_out_pin_enable_q;
  logic [DIV_W-1:0] div_ratio_q;
  logic             lp_q;
  logic             rtc_xtal_q;
  logic             wdt_xtal_q;
  logic             cfg_loaded_q;
  csc_sw_state_t    sw_q;
  logic [WAKE_W-1:0] wake_q;
  logic             hold_q;
  logic             cpu_en_q;
  logic             pclk_en_q;
  logic             cout_q;
  logic             cout_oe_q;
  logic             pclk_ph_q;

  // ==========================================
  // ahb-lite slave, zero wait states
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        take;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_CLK_CTRL:  rdata_d = {24'h00_0000, done_q, 3'b000, dbl_q, src_q};
      ADDR_TRIM:      rdata_d = {24'h00_0000, 1'b0, clock_out_pin_enable_q, trim_q};
      ADDR_DIV_RATIO: rdata_d = {{(32-DIV_W){1'b0}}, div_ratio_q};
      ADDR_AUX1:      rdata_d = {24'h00_0000, lp_q, 7'h00};
      ADDR_ROUTE:     rdata_d = {30'h0000_0000, wdt_xtal_q, rtc_xtal_q};
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic wr_ctrl;
  logic wr_trim;
  logic wr_div;
  logic wr_aux1;
  logic wr_route;
  // writes to clock control are dropped while a switch is pending
  assign wr_ctrl   = wr_pend_q & (addr_q == ADDR_CLK_CTRL) & done_q;
  assign wr_trim   = wr_pend_q & (addr_q == ADDR_TRIM);
  assign wr_div    = wr_pend_q & (addr_q == ADDR_DIV_RATIO);
  assign wr_aux1   = wr_pend_q & (addr_q == ADDR_AUX1);
  assign wr_route  = wr_pend_q & (addr_q == ADDR_ROUTE);

  // ==========================================
  // configuration capture after reset release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_loaded_q <= 1'b0;
    end else begin
      cfg_loaded_q <= 1'b1;
    end
  end

  // ==========================================
  // clock control register and switch sequencer
  logic start_sw;
  logic osc_tick;
  logic is_xtal;
  logic ext_rise;

  csc_edge_sync u_ext_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  (crystal_in_pin),
    .rise    (ext_rise)
  );

  // pick the tick of the active source, the pin edge in external mode
  always_comb begin
    case (src_q)
      SRC_RC:   osc_tick = rc_osc_tick;
      SRC_WDOG: osc_tick = wdog_osc_tick;
      SRC_EXT:  osc_tick = ext_rise;
      default:  osc_tick = xtal_osc_tick;
    endcase
  end

  // unused codes run from the crystal tick, so they count as crystal here too
  assign is_xtal  = (src_q != SRC_RC) & (src_q != SRC_WDOG) & (src_q != SRC_EXT);
  assign start_sw = wr_ctrl & (hwdata[2:0] != src_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_q      <= SRC_RC;
      src_next_q <= SRC_RC;
      dbl_q      <= 1'b0;
    end else if (!cfg_loaded_q) begin
      src_q      <= user_config_byte1[2:0];
      src_next_q <= user_config_byte1[2:0];
      dbl_q      <= user_config_byte2[CFG2_DBL_BIT];
    end else begin
      if (wr_ctrl) begin
        dbl_q      <= hwdata[CTRL_DBL_BIT];
        src_next_q <= hwdata[2:0];
      end
      if (sw_q == SW_OSC) begin
        src_q <= src_next_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sw_q   <= SW_IDLE;
      wake_q <= '0;
      done_q <= 1'b0;
      hold_q <= 1'b1;
    end else if (!cfg_loaded_q) begin
      sw_q   <= SW_OSC;
      done_q <= 1'b0;
    end else begin
      case (sw_q)
        SW_IDLE: begin
          if (start_sw) begin
            sw_q   <= SW_OSC;
            done_q <= 1'b0;
          end
        end
        SW_OSC: begin
          sw_q   <= SW_TIME;
          hold_q <= 1'b1;
          wake_q <= '0;
        end
        SW_TIME: begin
          // crystal: oscillator cycles then a timed tail; rc: timed only
          if (src_q == SRC_RC) begin
            wake_q <= wake_q + WAKE_W'(1);
            if (wake_q >= WAKE_W'(RC_WAKE_CYC - 1)) begin
              sw_q   <= SW_IDLE;
              done_q <= 1'b1;
              hold_q <= 1'b0;
            end
          end else if (is_xtal) begin
            if (wake_q < WAKE_W'(XTAL_OSC_CYC)) begin
              if (osc_tick) begin
                wake_q <= wake_q + WAKE_W'(1);
              end
            end else if (wake_q >= WAKE_W'(XTAL_OSC_CYC + XTAL_EXTRA_CYC - 1)) begin
              sw_q   <= SW_IDLE;
              done_q <= 1'b1;
              hold_q <= 1'b0;
            end else begin
              wake_q <= wake_q + WAKE_W'(1);
            end
          end else if (osc_tick) begin
            wake_q <= wake_q + WAKE_W'(1);
            if (wake_q >= WAKE_W'(WDEXT_OSC_CYC - 1)) begin
              sw_q   <= SW_IDLE;
              done_q <= 1'b1;
              hold_q <= 1'b0;
            end
          end
        end
        default: sw_q <= SW_IDLE;
      endcase
    end
  end

  // ==========================================
  // trim, clock output enable, low power select, source routing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_q          <= TRIM_FACTORY_RST;
      clock_out_pin_enable_q <= 1'b0;
    end else if (wr_trim) begin
      trim_q          <= hwdata[5:0];
      clock_out_pin_enable_q <= hwdata[TRIM_COUT_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lp_q <= 1'b0;
    end else if (wr_aux1) begin
      lp_q <= hwdata[AUX1_LP_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rtc_xtal_q <= 1'b0;
      wdt_xtal_q <= 1'b0;
    end else if (wr_route) begin
      rtc_xtal_q <= hwdata[0];
      wdt_xtal_q <= hwdata[1];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_ratio_q <= DIV_W'(DIV_RATIO_RST);
    end else if (wr_div) begin
      div_ratio_q <= hwdata[DIV_W-1:0];
    end
  end

  // ==========================================
  // cpu clock enable from the divider
  logic div_tick;
  csc_divider #(
    .W (DIV_W)
  ) u_div (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .tick_in  (osc_tick & ~hold_q),
    .ratio    (div_ratio_q),
    .tick_out (div_tick)
  );

  // the cpu never outruns the 10 MHz system clock, well below 18 MHz
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpu_en_q  <= 1'b0;
      pclk_en_q <= 1'b0;
      pclk_ph_q <= 1'b0;
    end else begin
      cpu_en_q  <= div_tick;
      pclk_en_q <= div_tick & pclk_ph_q;
      if (div_tick) begin
        pclk_ph_q <= ~pclk_ph_q;
      end
    end
  end

  // ==========================================
  // clock output on the shared crystal output pin
  logic cout_allowed;
  assign cout_allowed = ~is_xtal & ~rtc_xtal_q & ~wdt_xtal_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cout_q    <= 1'b0;
      cout_oe_q <= 1'b0;
    end else begin
      cout_oe_q <= clock_out_pin_enable_q & cout_allowed;
      if (!(clock_out_pin_enable_q && cout_allowed)) begin
        cout_q <= 1'b0;
      end else if (div_tick) begin
        cout_q <= ~cout_q;
      end
    end
  end

  assign cpu_clock_en         = cpu_en_q;
  assign periph_clock_en      = pclk_en_q;
  assign clock_out_pin        = cout_q;
  assign crystal_out_oe       = cout_oe_q;
  assign rc_trim              = trim_q;
  assign rc_doubler_bit       = dbl_q;
  assign low_power_access_sel = lp_q;
  assign osc_source_sel       = src_q;

  // ==========================================
  // checks
  reset_lp_clear_a: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> !low_power_access_sel)
    else $error("low power select not clear after reset");
  clock_out_pin_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    crystal_out_oe |-> $past(clock_out_pin_enable_q))
    else $error("clock output driven while disabled");
  clock_out_pin_xtal_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    crystal_out_oe |-> $past(cout_allowed))
    else $error("clock output while crystal in use");
  clock_out_pin_toggle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (crystal_out_oe && $past(crystal_out_oe) && $changed(clock_out_pin)) |-> $past(div_tick))
    else $error("clock output toggled without cpu tick");
  switch_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sw_q == SW_IDLE && start_sw) |=> !done_q)
    else $error("switch flag not cleared on start");
  write_block_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wr_pend_q && addr_q == ADDR_CLK_CTRL && !done_q) |=> $stable(src_next_q))
    else $error("clock control written while switching");
  trim_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_trim |=> rc_trim == $past(hwdata[5:0]))
    else $error("trim write not taken");
  wake_wd_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($rose(done_q) && !is_xtal && src_q != SRC_RC) |-> wake_q == WAKE_W'(WDEXT_OSC_CYC))
    else $error("watchdog or external wake ended early");
  div_pass_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (div_ratio_q == '0 && osc_tick && !hold_q) |=> cpu_clock_en)
    else $error("zero divider did not pass clock");
  pclk_half_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    periph_clock_en |-> cpu_clock_en)
    else $error("peripheral tick without cpu tick");
endmodule : csc_clock_ctrl

/* csc_osc_model.sv */
`timescale 1ns/1ns
module csc_osc_model #(
  parameter int RC_P  = 2,
  parameter int WD_P  = 25,
  parameter int EXT_P = 4,
  parameter int XT_P  = 3
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  output logic      rc_osc_tick,
  output logic      wdog_osc_tick,
  output logic      xtal_osc_tick,
  output logic      crystal_in_pin
);
  // ==========================================
  // free running sources: oscillators do not stop between switches
  int cnt_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign rc_osc_tick    = (cnt_q % RC_P) == 0;
  assign wdog_osc_tick  = (cnt_q % WD_P) == 0;
  assign xtal_osc_tick  = (cnt_q % XT_P) == 0;
  // square wave, far below the top rate of the pin
  assign crystal_in_pin = (cnt_q % EXT_P) < (EXT_P / 2);
endmodule : csc_osc_model

/* csc_clock_ctrl_tb.sv */
`timescale 1ns/1ns
module csc_clock_ctrl_tb;
  import csc_pkg::*;
  localparam int RC_P = 2;
  localparam int WD_P = 25;
  localparam int EX_P = 4;
  localparam int XT_P = 3;
  logic        clk_sys, reset_n, hwrite, hsel, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, osc_source_sel;
  logic        crystal_in_pin, rc_osc_tick, wdog_osc_tick, xtal_osc_tick;
  logic        cpu_clock_en, periph_clock_en, clock_out_pin, crystal_out_oe;
  logic        rc_doubler_bit, low_power_access_sel, co_prev;
  logic [5:0]  rc_trim;
  logic [7:0]  cfg1, cfg2;
  int          cyc = 0, cpu_n = 0, per_n = 0, tog_n = 0, t0 = 0;
  int          num_errors = 0, n_checks = 0;
  assign hready = hreadyout;
  csc_clock_ctrl csc_clock_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .user_config_byte1(cfg1), .user_config_byte2(cfg2), .crystal_in_pin(crystal_in_pin),
    .rc_osc_tick(rc_osc_tick), .wdog_osc_tick(wdog_osc_tick), .xtal_osc_tick(xtal_osc_tick),
    .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en),
    .clock_out_pin(clock_out_pin), .crystal_out_oe(crystal_out_oe), .rc_trim(rc_trim),
    .rc_doubler_bit(rc_doubler_bit), .low_power_access_sel(low_power_access_sel),
    .osc_source_sel(osc_source_sel));
  csc_osc_model #(.RC_P(RC_P), .WD_P(WD_P), .EXT_P(EX_P), .XT_P(XT_P)) csc_osc_model_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .rc_osc_tick(rc_osc_tick),
    .wdog_osc_tick(wdog_osc_tick), .xtal_osc_tick(xtal_osc_tick),
    .crystal_in_pin(crystal_in_pin));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================
  // event counters
  always @(posedge clk_sys) begin
    cyc++;
    if (cpu_clock_en === 1'b1) cpu_n++;
    if (periph_clock_en === 1'b1) per_n++;
    if (clock_out_pin !== co_prev) tog_n++;
    co_prev = clock_out_pin;
  end
  // ==========================================
  // report and compare
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  // ==========================================
  // bus master
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      close_out();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
    // registered outputs follow a cycle or two behind the write
    repeat (2) @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask : rd
  // ==========================================
  // scenarios
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t0 = cyc;
  endtask : do_reset
  task automatic reset_check(input logic [2:0] es, input logic ed);
    logic [31:0] d;
    repeat (2) @(posedge clk_sys);
    chk("source", es, osc_source_sel);
    chk("doubler", ed, rc_doubler_bit);
    chk("trim port", TRIM_FACTORY_RST, rc_trim);
    chk("lp port", 1'b0, low_power_access_sel);
    chk("hresp", 1'b0, hresp);
    rd(ADDR_TRIM, d);
    chk("trim reg", 7'h20, d[6:0]);
    rd(ADDR_AUX1, d);
    chk("lp reg", 1'b0, d[AUX1_LP_BIT]);
  endtask : reset_check
  task automatic lp_check();
    logic [31:0] d;
    // the watchdog source runs the cpu below 8 MHz here, so the bit may be set
    wr(ADDR_AUX1, 32'h0000_0080);
    wr(ADDR_TRIM, 32'h0000_0055);
    rd(ADDR_AUX1, d);
    chk("lp reg", 1'b1, d[AUX1_LP_BIT]);
    chk("lp port", 1'b1, low_power_access_sel);
  endtask : lp_check
  task automatic wait_done(input int lo, input int hi);
    logic [31:0] d;
    int k, c;
    c = cpu_n;
    k = 0;
    do begin
      rd(ADDR_CLK_CTRL, d);
      k++;
    end while (d[CTRL_DONE_BIT] !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      num_errors++;
      close_out();
    end
    chk_rng("wake cycles", lo, hi, cyc - t0);
    chk_rng("held clock", 0, 2, cpu_n - c);
  endtask : wait_done
  task automatic clock_out_pin_check();
    int c, t;
    wr(ADDR_TRIM, 32'h0000_0055);
    chk("trim port", 6'h15, rc_trim);
    for (int r = 3; r >= 0; r--) begin
      wr(ADDR_ROUTE, r);
      chk("clock_out_pin oe", r == 0, crystal_out_oe);
    end
    c = cpu_n;
    t = tog_n;
    repeat (1000) @(posedge clk_sys);
    chk_rng("toggles", cpu_n - c - 1, cpu_n - c + 1, tog_n - t);
    wr(ADDR_TRIM, 32'h0000_0015);
    chk("clock_out_pin oe", 1'b0, crystal_out_oe);
    wr(ADDR_TRIM, 32'h0000_0055);
  endtask : clock_out_pin_check
  task automatic switch_all();
    logic [2:0]  s [6] = '{SRC_EXT, SRC_XTAL_HI, SRC_XTAL_MED, SRC_XTAL_LO, SRC_WDOG, SRC_RC};
    int          xw = XTAL_OSC_CYC * XT_P + XTAL_EXTRA_CYC;
    int          w [6];
    logic [31:0] d;
    w = '{32 * EX_P, xw, xw, xw, 32 * WD_P, RC_WAKE_CYC};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CLK_CTRL, {28'h000_0000, 1'b1, s[i]});
      t0 = cyc - 2;
      rd(ADDR_CLK_CTRL, d);
      chk("done low", 1'b0, d[CTRL_DONE_BIT]);
      if (i == 0) wr(ADDR_CLK_CTRL, {28'h000_0000, 1'b1, SRC_RC});
      wait_done(w[i] - 30, w[i] + 45);
      chk("source", s[i], osc_source_sel);
      chk("clock_out_pin oe", s[i] > SRC_XTAL_LO, crystal_out_oe);
      chk("doubler", 1'b1, rc_doubler_bit);
    end
  endtask : switch_all
  task automatic div_check();
    int n [4] = '{0, 1, 3, 255};
    int c, p, e;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIV_RATIO, n[i]);
      repeat (1100) @(posedge clk_sys);
      c = cpu_n;
      p = per_n;
      repeat (4080) @(posedge clk_sys);
      e = (n[i] == 0) ? 4080 / RC_P : 4080 / (RC_P * 2 * n[i]);
      chk_rng("cpu pulses", e - 1, e + 1, cpu_n - c);
      chk_rng("periph pulses", (cpu_n - c) / 2 - 1, (cpu_n - c) / 2 + 1, per_n - p);
    end
  endtask : div_check
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    reset_n = 1'b0;
    htrans  = 2'h0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    haddr   = 32'h0000_0000;
    hsize   = 3'h2;
    hwdata  = 32'h0000_0000;
    co_prev = 1'b0;
    // brownout straps, bits 5 and 3, stay set in both strap sets
    cfg1    = 8'hFC;
    cfg2    = 8'h80;
    do_reset();
    reset_check(SRC_WDOG, 1'b1);
    lp_check();
    // second reset from other straps: rc source, doubler off
    cfg1    <= 8'hFB;
    cfg2    <= 8'h00;
    do_reset();
    reset_check(SRC_RC, 1'b0);
    wait_done(RC_WAKE_CYC - 30, RC_WAKE_CYC + 45);
    clock_out_pin_check();
    rd(8'h20, d);
    chk("unmapped", 32'h0000_0000, d);
    switch_all();
    div_check();
    close_out();
  end
endmodule : csc_clock_ctrl_tb
